// [design/sbsp_port.sv]
// Synchronous pipelined burst static memory port with its array.
`timescale 1ns/100ps
module sbsp_port
#(
    parameter int ADDR_W = sbsp_pkg::ADDR_W_DEF,
    parameter int LANES  = sbsp_pkg::LANES_DEF
)
(
    // Clock and reset.
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    // Address and access control.
    input  wire logic [ADDR_W-1:0]                 address,
    input  wire logic                              advance_or_load,
    input  wire logic                              clock_qualify_low,
    input  wire logic                              write_strobe_low,
    input  wire logic [LANES-1:0]                  byte_write_select_low,
    input  wire logic                              burst_mode_strap,
    // Chip selects.
    input  wire logic                              select_low_one,
    input  wire logic                              select_high_two,
    input  wire logic                              select_low_three,
    // Output enable.
    input  wire logic                              output_enable_low,
    // Data and parity lanes.
    input  wire logic [LANES*sbsp_pkg::BYTE_W-1:0] dq_in,
    input  wire logic [LANES-1:0]                  parity_lane_in,
    output logic      [LANES*sbsp_pkg::BYTE_W-1:0] dq_out,
    output logic      [LANES-1:0]                  parity_lane_out,
    output logic                                   data_oe
);
    import sbsp_pkg::*;

    localparam int MW = LANES * LANE_W;

    if ((ADDR_W <= BURST_W) || (LANES < 1))
    begin : g_chk
        $error("sbsp_port: ADDR_W must exceed the burst field and LANES must be positive.");
    end

    logic               qual;
    logic               sel;
    logic               mode_r;
    logic               mode_nxt;
    logic               mode_done_r;
    logic               mode_done_nxt;
    sbsp_op_t           s1_op_r;
    sbsp_op_t           s1_op_nxt;
    logic [ADDR_W-1:0]  s1_addr_r;
    logic [ADDR_W-1:0]  s1_addr_nxt;
    logic [LANES-1:0]   s1_bw_r;
    logic [LANES-1:0]   s1_bw_nxt;
    logic [ADDR_W-1:0]  base_r;
    logic [ADDR_W-1:0]  base_nxt;
    logic [BURST_W-1:0] cnt_r;
    logic [BURST_W-1:0] cnt_nxt;
    logic [BURST_W-1:0] cnt_adv;
    logic [ADDR_W-1:0]  burst_addr;
    sbsp_op_t           s2_op_r;
    sbsp_op_t           s2_op_nxt;
    logic [ADDR_W-1:0]  s2_addr_r;
    logic [ADDR_W-1:0]  s2_addr_nxt;
    logic [LANES-1:0]   s2_bw_r;
    logic [LANES-1:0]   s2_bw_nxt;
    logic               data_oe_r;
    logic               data_oe_nxt;
    logic               mem_wr_en;
    logic               mem_rd_en;
    logic [MW-1:0]      wr_word;
    logic [MW-1:0]      rd_word;

    // Edge qualification and chip selection.
    assign qual    = !clock_qualify_low;
    assign sel     = !select_low_one && select_high_two && !select_low_three;
    assign cnt_adv = cnt_r + 2'h1;

    // Each parity bit travels with its byte in one stored lane.
    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
        assign wr_word[l*LANE_W +: LANE_W]  = {parity_lane_in[l], dq_in[l*BYTE_W +: BYTE_W]};
        assign dq_out[l*BYTE_W +: BYTE_W]   = rd_word[l*LANE_W +: BYTE_W];
        assign parity_lane_out[l]           = rd_word[l*LANE_W + BYTE_W];
    end

    assign data_oe = data_oe_r;

    // Burst order strap is caught once after reset.
    always_comb
    begin
        mode_nxt      = mode_r;
        mode_done_nxt = 1'h1;
        if (!mode_done_r)
        begin
            mode_nxt = burst_mode_strap;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r      <= MODE_RESET;
            mode_done_r <= 1'h0;
        end
        else
        begin
            mode_r      <= mode_nxt;
            mode_done_r <= mode_done_nxt;
        end
    end

    sbsp_burst #(
        .ADDR_W     (ADDR_W)
    ) u_burst (
        .base_addr  (base_r),
        .step       (cnt_adv),
        .interleave (mode_r),
        .burst_addr (burst_addr)
    );

    // Command stage.
    always_comb
    begin
        s1_op_nxt   = s1_op_r;
        s1_addr_nxt = s1_addr_r;
        s1_bw_nxt   = s1_bw_r;
        base_nxt    = base_r;
        cnt_nxt     = cnt_r;
        if (qual)
        begin
            if (!advance_or_load)
            begin
                base_nxt    = address;
                s1_addr_nxt = address;
                cnt_nxt     = CNT_RESET;
                if (sel)
                begin
                    s1_op_nxt = write_strobe_low ? OP_READ : OP_WRITE;
                end
                else
                begin
                    s1_op_nxt = OP_IDLE;
                end
            end
            else
            begin
                cnt_nxt     = cnt_adv;
                s1_addr_nxt = burst_addr;
            end
            s1_bw_nxt = (s1_op_nxt == OP_WRITE) ? ~byte_write_select_low : '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_op_r   <= OP_RESET;
            s1_addr_r <= '0;
            s1_bw_r   <= '0;
            base_r    <= '0;
            cnt_r     <= CNT_RESET;
        end
        else
        begin
            s1_op_r   <= s1_op_nxt;
            s1_addr_r <= s1_addr_nxt;
            s1_bw_r   <= s1_bw_nxt;
            base_r    <= base_nxt;
            cnt_r     <= cnt_nxt;
        end
    end

    // Data stage and output drive.
    always_comb
    begin
        s2_op_nxt   = s2_op_r;
        s2_addr_nxt = s2_addr_r;
        s2_bw_nxt   = s2_bw_r;
        if (qual)
        begin
            s2_op_nxt   = s1_op_r;
            s2_addr_nxt = s1_addr_r;
            s2_bw_nxt   = s1_bw_r;
        end
        data_oe_nxt = (s2_op_nxt == OP_READ) && !output_enable_low;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s2_op_r   <= OP_RESET;
            s2_addr_r <= '0;
            s2_bw_r   <= '0;
            data_oe_r <= OE_RESET;
        end
        else
        begin
            s2_op_r   <= s2_op_nxt;
            s2_addr_r <= s2_addr_nxt;
            s2_bw_r   <= s2_bw_nxt;
            data_oe_r <= data_oe_nxt;
        end
    end

    assign mem_rd_en = qual && (s1_op_r == OP_READ);
    assign mem_wr_en = qual && (s2_op_r == OP_WRITE);

    sbsp_mem #(
        .ADDR_W   (ADDR_W),
        .LANES    (LANES)
    ) u_mem (
        .clk      (clk),
        .rst_n    (rst_n),
        .wr_en    (mem_wr_en),
        .wr_addr  (s2_addr_r),
        .wr_lanes (s2_bw_r),
        .wr_word  (wr_word),
        .rd_en    (mem_rd_en),
        .rd_addr  (s1_addr_r),
        .rd_word  (rd_word)
    );

    // Checks on the pipeline.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_load_addr: assert property (
        qual && !advance_or_load && sel |=> s1_addr_r == $past(address)
    ) else $error("Loaded address not taken.");

    a_adv_count: assert property (
        qual && advance_or_load |=> cnt_r == $past(cnt_r) + 2'h1
    ) else $error("Burst counter did not step.");

    a_burst_order: assert property (
        qual && advance_or_load && mode_done_r |=> s1_addr_r[BURST_W-1:0] ==
            (mode_r ? ($past(base_r[BURST_W-1:0]) ^ cnt_r)
                    : BURST_W'($past(base_r[BURST_W-1:0]) + cnt_r))
    ) else $error("Burst location out of order.");

    a_stall_hold: assert property (
        clock_qualify_low |=> $stable(s1_op_r) && $stable(s2_op_r) && $stable(dq_out)
            && $stable(cnt_r) && $stable(s1_addr_r)
    ) else $error("State moved on an unqualified edge.");

    a_desel_load: assert property (
        qual && !advance_or_load && !sel |=>
            (s1_op_r == OP_IDLE) and (qual |=> !data_oe && s2_op_r == OP_IDLE)
    ) else $error("Deselected load started an access.");

    a_oe_pin: assert property (
        output_enable_low |=> !data_oe
    ) else $error("Data driven with output enable high.");

    a_no_drive: assert property (
        data_oe |-> s2_op_r == OP_READ
    ) else $error("Data driven outside a read data phase.");

    a_read_pipe: assert property (
        qual && !advance_or_load && sel && write_strobe_low && !output_enable_low
            ##1 qual && !output_enable_low |=> data_oe && s2_op_r == OP_READ
    ) else $error("Read data not presented one edge after load.");

    a_write_lanes: assert property (
        qual && !advance_or_load && sel && !write_strobe_low ##1 qual |=>
            s2_op_r == OP_WRITE && !data_oe && s2_bw_r == $past(~byte_write_select_low, 2)
    ) else $error("Write lane selects not carried to the data phase.");

    a_mode_static: assert property (
        mode_done_r |=> $stable(mode_r)
    ) else $error("Burst order changed during operation.");

    c_read: cover property (
        qual && !advance_or_load && sel && write_strobe_low ##1 qual ##1 data_oe
    );

    c_write: cover property (
        qual && !advance_or_load && sel && !write_strobe_low ##1 qual ##1 mem_wr_en
    );

    c_burst: cover property (
        qual && s1_op_r == OP_READ && advance_or_load ##1 qual && advance_or_load
    );

    c_stall: cover property (
        s2_op_r == OP_READ && clock_qualify_low ##1 clock_qualify_low
    );

endmodule

// [design/sbsp_pkg.sv]
// Shared constants and types for the synchronous burst static memory port.
package sbsp_pkg;

    // Default geometry of the array.
    localparam int ADDR_W_DEF = 6;
    localparam int LANES_DEF  = 4;
    localparam int BYTE_W     = 8;
    localparam int LANE_W     = BYTE_W + 1;

    // Burst field sits in the low address bits.
    localparam int BURST_W    = 2;
    localparam int BURST_LSB  = 0;

    // Access kinds held in the pipeline.
    typedef enum logic [2:0]
    {
        OP_IDLE  = 3'h1,
        OP_READ  = 3'h2,
        OP_WRITE = 3'h4
    } sbsp_op_t;

    // Reset values.
    localparam sbsp_op_t           OP_RESET   = OP_IDLE;
    localparam logic [BURST_W-1:0] CNT_RESET  = 2'h0;
    localparam logic               MODE_RESET = 1'h1;
    localparam logic               OE_RESET   = 1'h0;

endpackage

// [design/sbsp_burst.sv]
// Burst location generator for linear and interleaved order.
`timescale 1ns/100ps
module sbsp_burst
#(
    parameter int ADDR_W = sbsp_pkg::ADDR_W_DEF
)
(
    // Burst start and step.
    input  wire logic [ADDR_W-1:0]            base_addr,
    input  wire logic [sbsp_pkg::BURST_W-1:0] step,
    input  wire logic                         interleave,
    // Location of this step.
    output logic      [ADDR_W-1:0]            burst_addr
);
    import sbsp_pkg::*;

    logic [BURST_W-1:0] low;

    always_comb
    begin
        if (interleave)
        begin
            low = base_addr[BURST_LSB +: BURST_W] ^ step;
        end
        else
        begin
            low = base_addr[BURST_LSB +: BURST_W] + step;
        end
        burst_addr = {base_addr[ADDR_W-1:BURST_W], low};
    end

endmodule

// [design/sbsp_mem.sv]
// Flip-flop array with per-lane writes and a registered, bypassed read.
`timescale 1ns/100ps
module sbsp_mem
#(
    parameter int ADDR_W = sbsp_pkg::ADDR_W_DEF,
    parameter int LANES  = sbsp_pkg::LANES_DEF
)
(
    // Clock and reset.
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    // Write side.
    input  wire logic                                 wr_en,
    input  wire logic [ADDR_W-1:0]                    wr_addr,
    input  wire logic [LANES-1:0]                     wr_lanes,
    input  wire logic [LANES*sbsp_pkg::LANE_W-1:0]    wr_word,
    // Read side.
    input  wire logic                                 rd_en,
    input  wire logic [ADDR_W-1:0]                    rd_addr,
    output logic      [LANES*sbsp_pkg::LANE_W-1:0]    rd_word
);
    import sbsp_pkg::*;

    localparam int DEPTH = 2 ** ADDR_W;

    logic [LANE_W-1:0]       mem_r [DEPTH][LANES];
    logic [LANES*LANE_W-1:0] rd_nxt;

    // A write landing on the read location in the same edge is forwarded.
    always_comb
    begin
        rd_nxt = rd_word;
        if (rd_en)
        begin
            for (int l = 0; l < LANES; l++)
            begin
                rd_nxt[l*LANE_W +: LANE_W] = mem_r[rd_addr][l];
                if (wr_en && wr_lanes[l] && (wr_addr == rd_addr))
                begin
                    rd_nxt[l*LANE_W +: LANE_W] = wr_word[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_word <= '0;
        end
        else
        begin
            rd_word <= rd_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        for (int l = 0; l < LANES; l++)
        begin
            if (wr_en && wr_lanes[l])
            begin
                mem_r[wr_addr][l] <= wr_word[l*LANE_W +: LANE_W];
            end
        end
    end

endmodule

// [dv/sbsp_ctrl_model.sv]
// Controller model driving commands, selects and write data lanes.
`timescale 1ns/100ps
module sbsp_ctrl_model
#(
    parameter int AW = 6,
    parameter int LN = 4,
    parameter int W  = LN*sbsp_pkg::LANE_W
)
(
    // Clock.
    input  wire logic          clk,
    // Command and selects.
    output logic      [AW-1:0] address,
    output logic               advance_or_load,
    output logic               clock_qualify_low,
    output logic               write_strobe_low,
    output logic      [LN-1:0] byte_write_select_low,
    output logic               select_low_one,
    output logic               select_high_two,
    output logic               select_low_three,
    // Lanes as {parity, data}.
    input  wire logic [W-1:0]  rd_word,
    input  wire logic          oe,
    output logic      [W-1:0]  wr_word
);
    import sbsp_pkg::*;
    logic         kind_wr;
    logic         dsel;
    logic         s1_wr;
    logic         s2_wr;
    logic [W-1:0] data_now;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_d;
    logic [W-1:0] drv;

    assign wr_word = oe ? rd_word : drv;

    initial
    begin
        address = '0;
        advance_or_load = 1'b0;
        clock_qualify_low = 1'b0;
        write_strobe_low = 1'b1;
        byte_write_select_low = '1;
        {select_low_one, select_high_two, select_low_three} = 3'b110;
        kind_wr = 1'b0;
        dsel = 1'b1;
        s1_wr = 1'b0;
        s2_wr = 1'b0;
        data_now = '0;
        drv = '0;
    end

    // Released lanes toggle each cycle so stale data never looks valid.
    always @(posedge clk)
    begin
        if (!clock_qualify_low)
        begin
            s2_wr <= s1_wr;
            s2_d <= s1_d;
            s1_wr <= kind_wr;
            s1_d <= data_now;
        end
        #1;
        drv = s2_wr ? s2_d : ~drv;
    end

    task automatic cmd(input logic adv, input logic wr, input logic [AW-1:0] a,
                       input logic [LN-1:0] bwl, input logic [2:0] sel, input logic [W-1:0] d);
        @(posedge clk);
        #1;
        advance_or_load = adv && !dsel;
        address = a;
        write_strobe_low = ~wr;
        byte_write_select_low = bwl;
        {select_low_one, select_high_two, select_low_three} = sel;
        if (!adv)
        begin
            kind_wr = wr && (sel == 3'b010);
            dsel = (sel != 3'b010);
        end
        data_now = d;
    endtask

    task automatic stall(input logic v);
        @(posedge clk);
        #1;
        clock_qualify_low = v;
    endtask
endmodule

// [dv/test_sync_burst_sram_port.sv]
// Self-checking bench for the burst static memory port.
`timescale 1ns/100ps
module test_sync_burst_sram_port;
    import sbsp_pkg::*;
    localparam int AW = ADDR_W_DEF;
    localparam int LN = LANES_DEF;
    localparam int W  = LN*LANE_W;
    logic               clk;
    logic               rst_n;
    logic               output_enable_low;
    logic               burst_mode_strap;
    wire logic [AW-1:0] address;
    wire logic          advance_or_load;
    wire logic          clock_qualify_low;
    wire logic          write_strobe_low;
    wire logic [LN-1:0] byte_write_select_low;
    wire logic          select_low_one;
    wire logic          select_high_two;
    wire logic          select_low_three;
    wire logic [31:0]   dq_in;
    wire logic [LN-1:0] parity_lane_in;
    wire logic [31:0]   dq_out;
    wire logic [LN-1:0] parity_lane_out;
    wire logic          data_oe;
    int                 failures;
    int                 checks_done;

    sbsp_port i_sbsp_port
    (
        .clk(clk), .rst_n(rst_n), .address(address), .advance_or_load(advance_or_load),
        .clock_qualify_low(clock_qualify_low), .write_strobe_low(write_strobe_low),
        .byte_write_select_low(byte_write_select_low), .burst_mode_strap(burst_mode_strap),
        .select_low_one(select_low_one), .select_high_two(select_high_two),
        .select_low_three(select_low_three), .output_enable_low(output_enable_low),
        .dq_in(dq_in), .parity_lane_in(parity_lane_in), .dq_out(dq_out),
        .parity_lane_out(parity_lane_out), .data_oe(data_oe)
    );

    sbsp_ctrl_model i_sbsp_ctrl_model
    (
        .clk(clk), .address(address), .advance_or_load(advance_or_load),
        .clock_qualify_low(clock_qualify_low), .write_strobe_low(write_strobe_low),
        .byte_write_select_low(byte_write_select_low), .select_low_one(select_low_one),
        .select_high_two(select_high_two), .select_low_three(select_low_three),
        .rd_word({parity_lane_out, dq_out}), .oe(data_oe), .wr_word({parity_lane_in, dq_in})
    );

    always #2 clk = ~clk;

    task automatic wrap_up();
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic see(input logic [W-1:0] exp, input logic oe_exp);
        checks_done++;
        if ({parity_lane_out, dq_out, data_oe} !== {exp, oe_exp})
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     {parity_lane_out, dq_out, data_oe}, {exp, oe_exp});
        end
    endtask

    task automatic see_off();
        checks_done++;
        if (data_oe !== 1'b0)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected 0", $time, data_oe);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [W-1:0] d, input logic [LN-1:0] bwl);
        i_sbsp_ctrl_model.cmd(1'b0, 1'b1, a, bwl, 3'b010, d);
    endtask

    task automatic rd(input logic [AW-1:0] a);
        i_sbsp_ctrl_model.cmd(1'b0, 1'b0, a, '1, 3'b010, '0);
    endtask

    task automatic nop();
        i_sbsp_ctrl_model.cmd(1'b0, 1'b0, '0, '1, 3'b110, '0);
    endtask

    task automatic adv(input logic [W-1:0] d);
        i_sbsp_ctrl_model.cmd(1'b1, 1'b0, '0, '0, 3'b010, d);
    endtask

    task automatic do_reset(input logic strap);
        rst_n = 1'b0;
        burst_mode_strap = strap;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
    endtask

    task automatic s_rw();
        wr(6'h05, 36'h1_1122_3344, 4'h0);
        wr(6'h06, 36'h2_5566_7788, 4'h0);
        rd(6'h05);
        see_off();
        rd(6'h06);
        see_off();
        wr(6'h07, 36'hf_0f0f_0f0f, 4'h0);
        see(36'h1_1122_3344, 1'b1);
        rd(6'h07);
        see(36'h2_5566_7788, 1'b1);
        nop();
        see_off();
        nop();
        see(36'hf_0f0f_0f0f, 1'b1);
    endtask

    task automatic s_lanes();
        wr(6'h08, 36'hf_ffff_ffff, 4'h0);
        wr(6'h08, 36'h0_0000_0000, 4'ha);
        rd(6'h08);
        nop();
        nop();
        see(36'ha_ff00_ff00, 1'b1);
    endtask

    task automatic s_sel();
        wr(6'h09, 36'h3_cafe_f00d, 4'h0);
        for (int i = 0; i < 3; i++)
        begin
            i_sbsp_ctrl_model.cmd(1'b0, 1'b1, 6'h09, 4'h0, 3'b010 ^ 3'(1 << i), '0);
            see_off();
        end
        rd(6'h09);
        see_off();
        nop();
        see_off();
        nop();
        see(36'h3_cafe_f00d, 1'b1);
    endtask

    task automatic s_stall();
        wr(6'h20, 36'h5_1111_2222, 4'h0);
        wr(6'h21, 36'h6_3333_4444, 4'h0);
        rd(6'h20);
        rd(6'h21);
        i_sbsp_ctrl_model.stall(1'b1);
        wr(6'h20, 36'h0_dead_beef, 4'h0);
        see(36'h5_1111_2222, 1'b1);
        rd(6'h21);
        see(36'h5_1111_2222, 1'b1);
        i_sbsp_ctrl_model.stall(1'b0);
        nop();
        see(36'h6_3333_4444, 1'b1);
        rd(6'h20);
        nop();
        nop();
        see(36'h5_1111_2222, 1'b1);
    endtask

    task automatic s_oe();
        wr(6'h30, 36'h9_aaaa_5555, 4'h0);
        rd(6'h30);
        rd(6'h30);
        output_enable_low = 1'b1;
        nop();
        output_enable_low = 1'b0;
        see(36'h9_aaaa_5555, 1'b0);
        nop();
        see(36'h9_aaaa_5555, 1'b1);
    endtask

    task automatic s_burst(input logic strap);
        logic [1:0] loc;
        do_reset(strap);
        wr(6'h11, 36'h0_0000_00a0, 4'h0);
        for (int k = 1; k < 4; k++)
            adv(36'h0_0000_00a0 + k);
        nop();
        for (int k = 0; k < 4; k++)
        begin
            loc = strap ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
            rd({4'h4, loc});
            nop();
            nop();
            see(36'h0_0000_00a0 + k, 1'b1);
        end
        rd(6'h11);
        adv('0);
        for (int k = 0; k < 4; k++)
        begin
            if (k < 2)
            begin
                adv('0);
            end
            else
            begin
                nop();
            end
            see(36'h0_0000_00a0 + k, 1'b1);
        end
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        output_enable_low = 1'b0;
        burst_mode_strap = 1'b1;
        failures = 0;
        checks_done = 0;
        do_reset(1'b1);
        s_rw();
        s_lanes();
        s_sel();
        s_stall();
        s_oe();
        s_burst(1'b1);
        s_burst(1'b0);
        wrap_up();
    end

    initial
    begin
        #20000;
        failures++;
        wrap_up();
    end
endmodule
